// ### tb_verified_output_monitor.sv
// Self-checking testbench for the verified output monitor
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin err_total++; \
    $display("BAD %s exp %h got %h", nm, ex, gt); end end
module tb_verified_output_monitor;
    timeunit 1ns;
    timeprecision 1ns;
    logic                mclk = 1'b0;              // System clock
    logic                sys_rst;                  // Async reset, active high
    logic [15:0]         lo, hi, sw_lo, sw_hi;     // Command and read-back words
    logic                cmd_valid;                // Update strobe
    vom_pkg::vom_cfg_t   cfg;                      // Host configuration
    vom_pkg::vom_field_t field_in;                 // Sensed field view
    logic [31:0]         short_pts, backfeed, drv, led, sbits, v;
    logic [31:0]         seed = 32'h0000_7eb8;     // Fixed start for repeatability
    logic [3:0]          sup_ok, fuse_ok;          // Field supplies and fuses
    logic [7:0]          status;                   // Group status byte
    logic                fault_led, active_led;    // Indicators
    int                  err_total = 0;            // Mismatches
    int                  checks = 0;               // Comparisons made
    vom_top DUT (.mclk(mclk), .sys_rst(sys_rst), .cmd_word_lo(lo), .cmd_word_hi(hi),
        .cmd_valid(cmd_valid), .cfg(cfg), .field_in(field_in), .sense_word_lo(sw_lo),
        .sense_word_hi(sw_hi), .sense_bits(sbits), .status_byte(status), .out_drive(drv),
        .out_led(led), .fault_led(fault_led), .active_led(active_led));
    vom_field_model u_field (.out_drive(drv), .short_pts(short_pts), .backfeed(backfeed),
        .supply_ok(sup_ok), .fuse_ok(fuse_ok), .field_in(field_in));
    // Free-running clock
    initial begin
        forever #(vom_pkg::CLK_NS / 2) mclk = ~mclk;
    end
    // Xorshift generator for command patterns
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // Word pair to points and back: point 1 sits at the low word's top bit
    function automatic logic [31:0] flip(input logic [31:0] w);
        for (int i = 0; i < 16; i++) begin
            flip[i] = w[15-i];
            flip[16+i] = w[31-i];
        end
    endfunction : flip
    // Expected read-back for a mode, command and sensed state
    function automatic logic [31:0] rbx(input int m, input logic [31:0] c, input logic [31:0] a);
        case (m)
            0: return ~(c ^ a);
            1: return c ^ a;
            default: return a;
        endcase
    endfunction : rbx
    // Expected status: raw mode only flags highs on points commanded off
    function automatic logic [7:0] stx(input int m, input logic [31:0] c, input logic [31:0] a,
                                       input logic [3:0] vok);
        logic [31:0] mis;
        mis = (m == 2) ? (a & ~c) : (c ^ a);
        stx[3:0] = ~vok;
        for (int g = 0; g < 4; g++) stx[4+g] = |mis[8*g +: 8];
    endfunction : stx
    // One strobe with both words, then let drivers and sensing settle
    task automatic send(input logic [31:0] p);
        @(posedge mclk);
        {hi, lo} <= flip(p);
        cmd_valid <= 1'b1;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask : send
    // Compare every view of the port except active_led; sampled off the edge
    task automatic expect_pts(input logic [31:0] d, input logic [31:0] rb, input logic [7:0] st);
        #1;
        `CHK("out_drive", d, drv)
        `CHK("out_led", d, led)
        `CHK("sense words", rb, flip({sw_hi, sw_lo}))
        `CHK("sense_bits", rb, sbits)
        `CHK("status_byte", st, status)
        `CHK("fault_led", |st, fault_led)
    endtask : expect_pts
    // Walk health, fault and actual views of one state
    task automatic views(input logic [31:0] c, input logic [31:0] a, input logic [31:0] d);
        for (int m = 0; m < 4; m++) begin
            if (m == 2) continue;
            @(posedge mclk);
            cfg.rb_mode <= vom_pkg::vom_rb_mode_t'(m);
            repeat (4) @(posedge mclk);
            expect_pts(d, rbx(m, c, a), stx(m, c, a, 4'hF));
        end
    endtask : views
    // Verdict and end of run
    task automatic conclude();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude
    // Watchdog well beyond the two loss waits
    initial begin
        repeat (60000) @(posedge mclk);
        err_total++;
        conclude();
    end
    // Main sequence
    initial begin
        sys_rst = 1'b1;
        {hi, lo, cmd_valid, short_pts, backfeed} = '0;
        cfg = '0;
        {sup_ok, fuse_ok} = 8'hFF;
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        #1 `CHK("active after reset", 1'b0, active_led)
        // Random patterns through every read-back mode
        for (int n = 0; n < 24; n++) begin
            cfg.rb_mode <= vom_pkg::vom_rb_mode_t'(n % 4);
            v = rnd();
            send(v);
            expect_pts(v, rbx(n % 4, v, v), stx(n % 4, v, v, 4'hF));
        end
        // Raw mode: high on an off point flags, high on an on point does not
        cfg.rb_mode <= vom_pkg::VOM_RB_RAW;
        backfeed <= 32'h0000_0101;
        send(32'h0000_00FF);
        expect_pts(32'h0000_00FF, 32'h0000_01FF, 8'h20);
        // Supply loss in group 1, blown fuse in group 3
        {backfeed, sup_ok, fuse_ok} <= {32'h0, 8'hD7};
        send(32'h0);
        expect_pts(32'h0, 32'h0, 8'h0A);
        // Latched fault on point 20, off command, clear, on again
        {sup_ok, fuse_ok} <= 8'hFF;
        short_pts <= 32'h0008_0000;
        send(32'h0008_0001);
        views(32'h0008_0001, 32'h1, 32'h1);
        send(32'h1);
        views(32'h0008_0001, 32'h1, 32'h1);
        short_pts <= 32'h0;
        repeat (8) @(posedge mclk);
        #1 `CHK("latched point", 32'h1, drv)
        send(32'h0008_0001);
        views(32'h0008_0001, 32'h0008_0001, 32'h0008_0001);
        // Automatic restart: retry until the short goes, off clears all
        cfg.auto_restart <= 1'b1;
        short_pts <= 32'h0008_0000;
        repeat (8) @(posedge mclk);
        expect_pts(32'h1, 32'h1, 8'h40);
        short_pts <= 32'h0;
        repeat (vom_pkg::COOL_CYC + 20) @(posedge mclk);
        expect_pts(32'h0008_0001, 32'h0008_0001, 8'h00);
        short_pts <= 32'h0008_0000;
        repeat (8) @(posedge mclk);
        send(32'h1);
        expect_pts(32'h1, 32'h1, 8'h00);
        // Communication loss: per-group fail states, then all off
        {short_pts, cfg.auto_restart, cfg.fail_hold} <= {32'h0, 1'b0, 4'b0101};
        for (int sd = 0; sd < 2; sd++) begin
            cfg.shut_disable <= sd[0];
            send(32'hFFFF_FFFF);
            #1 `CHK("active", 1'b1, active_led)
            repeat (vom_pkg::TIMEOUT_CYC + 20) @(posedge mclk);
            #1 `CHK("active lost", 1'b0, active_led)
            `CHK("loss drive", (sd == 1) ? 32'h0 : 32'h00FF_00FF, drv)
        end
        conclude();
    end
endmodule : tb_verified_output_monitor

// ### vom_field_model.sv
// Field-side model: loads, shorted points, back-fed highs, group supplies
module vom_field_model (
    input  wire logic [vom_pkg::NPTS-1:0] out_drive,  // Drivers from the port
    input  wire logic [vom_pkg::NPTS-1:0] short_pts,  // Points pulled low by a fault
    input  wire logic [vom_pkg::NPTS-1:0] backfeed,   // Points fed high from outside
    input  wire logic [vom_pkg::NGRP-1:0] supply_ok,  // Group supplies present
    input  wire logic [vom_pkg::NGRP-1:0] fuse_ok,    // Group fuses intact
    output vom_pkg::vom_field_t           field_in    // Sensed view for the port
);
    timeunit 1ns;
    timeprecision 1ns;
    // Terminal level; a dead supply cannot source, so a driven point reads low
    always_comb begin
        for (int i = 0; i < vom_pkg::NPTS; i++) begin
            field_in.sense_hi[i] = (out_drive[i] & ~short_pts[i] & supply_ok[i / 8]
                                   & fuse_ok[i / 8]) | backfeed[i];
        end
        field_in.supply_ok = supply_ok;
        field_in.fuse_ok   = fuse_ok;
    end
endmodule : vom_field_model

// ### vom_pkg.sv
// Package of constants and types for the verified output monitor
package vom_pkg;
    localparam int NPTS          = 32;          // Points on the port
    localparam int NGRP          = 4;           // Groups of points
    localparam int GPTS          = 8;           // Points per group
    localparam int WORD_W        = 16;          // Command and sense word width
    localparam int STAT_VF_LSB   = 0;           // Voltage-fault bits 3:0
    localparam int STAT_MC_LSB   = 4;           // Miscompare bits 7:4
    localparam int TIMEOUT_W     = 24;          // Width of the loss timer
    localparam int TIMEOUT_NS    = 1000000;     // Communication loss time, ns
    localparam int CLK_NS        = 100;         // Clock period, ns
    localparam int TIMEOUT_CYC   = TIMEOUT_NS / CLK_NS; // Longest time rounds down
    localparam int COOL_NS       = 100000;      // Cooling time before a retry, ns
    localparam int COOL_CYC      = COOL_NS / CLK_NS;
    localparam int COOL_W        = 12;          // Width of the cooling counter
    localparam logic [NPTS-1:0] CMD_RESET = 32'h0000_0000; // Outputs off at reset

    // Read-back meaning of the sense words
    typedef enum logic [1:0] {
        VOM_RB_HEALTH,
        VOM_RB_FAULT,
        VOM_RB_RAW,
        VOM_RB_ACTUAL
    } vom_rb_mode_t;

    // Configuration from the host side
    typedef struct packed {
        vom_rb_mode_t      rb_mode;      // Read-back meaning
        logic              shut_disable; // 1: all off on loss, 0: per-group fail state
        logic [NGRP-1:0]   fail_hold;    // 1: hold last value, 0: outputs off
        logic              auto_restart; // 1: retry after cooling
    } vom_cfg_t;

    // Field-side sensing per point and group
    typedef struct packed {
        logic [NPTS-1:0]   sense_hi;     // Output terminal sensed high
        logic [NGRP-1:0]   supply_ok;    // Group field supply present
        logic [NGRP-1:0]   fuse_ok;      // Group fuse intact
    } vom_field_t;
endpackage : vom_pkg

// ### vom_top.sv
// Verified output monitor: command words, read-back, fault latching
module vom_top (
    input  wire logic                        mclk,
    input  wire logic                        sys_rst,
    input  wire logic [vom_pkg::WORD_W-1:0]  cmd_word_lo,    // command_word_low
    input  wire logic [vom_pkg::WORD_W-1:0]  cmd_word_hi,    // command_word_high
    input  wire logic                        cmd_valid,      // One-cycle update strobe
    input  wire vom_pkg::vom_cfg_t           cfg,            // Host configuration
    input  wire vom_pkg::vom_field_t         field_in,       // Asynchronous field sensing
    output logic [vom_pkg::WORD_W-1:0]       sense_word_lo,  // sense_word_low
    output logic [vom_pkg::WORD_W-1:0]       sense_word_hi,  // sense_word_high
    output logic [vom_pkg::NPTS-1:0]         sense_bits,     // Bit references, point 1 at 0
    output logic [7:0]                       status_byte,    // Group status byte
    output logic [vom_pkg::NPTS-1:0]         out_drive,      // Output drivers
    output logic [vom_pkg::NPTS-1:0]         out_led,        // Point indicators
    output logic                             fault_led,      // Red fault indicator
    output logic                             active_led      // Communication present
);
    localparam int NP = vom_pkg::NPTS;
    localparam int NG = vom_pkg::NGRP;
    localparam int GP = vom_pkg::GPTS;

    // Field synchronisers; stage one is only read by stage two
    vom_pkg::vom_field_t fs1_q, fs2_q;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            fs1_q <= '0;
            fs2_q <= '0;
        end else begin
            fs1_q <= field_in;
            fs2_q <= fs1_q;
        end
    end

    // Command unpacking: index 0 is point 1
    logic [NP-1:0] cmd_new;
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            cmd_new[i]      = cmd_word_lo[15-i];
            cmd_new[16 + i] = cmd_word_hi[15-i];
        end
    end

    // Command register, loss timer and loss flag
    logic [NP-1:0]                   cmd_q, cmd_d;       // Last commanded values
    logic [vom_pkg::TIMEOUT_W-1:0]   tmo_q, tmo_d;       // Cycles since last update
    logic                            lost_q, lost_d;     // Communication lost
    always_comb begin
        cmd_d  = cmd_q;
        tmo_d  = tmo_q;
        lost_d = lost_q;
        if (cmd_valid) begin
            cmd_d  = cmd_new;
            tmo_d  = '0;
            lost_d = 1'b0;                                   // Updates resume
        end else if (tmo_q >= vom_pkg::TIMEOUT_W'(vom_pkg::TIMEOUT_CYC - 1)) begin
            lost_d = 1'b1;
        end else begin
            tmo_d = tmo_q + 1'b1;
        end
    end
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_q  <= vom_pkg::CMD_RESET;
            tmo_q  <= '0;
            lost_q <= 1'b1;   // No host yet, so outputs stay off
        end else begin
            cmd_q  <= cmd_d;
            tmo_q  <= tmo_d;
            lost_q <= lost_d;
        end
    end

    // Effective command after shutdown handling
    logic [NP-1:0] eff_cmd;
    always_comb begin
        for (int p = 0; p < NP; p++) begin
            if (!lost_q)
                eff_cmd[p] = cmd_q[p];
            else if (cfg.shut_disable)
                eff_cmd[p] = 1'b0;
            else
                eff_cmd[p] = cfg.fail_hold[p / GP] & cmd_q[p];
        end
    end

    // Per-point latch of faults, and the cooling timer for auto restart.
    // A fault is an on-command whose terminal did not follow.
    logic [NP-1:0]               lat_q, lat_d;     // Point latched off by fault
    logic [NP-1:0]               prev_q, prev_d;   // Previous effective command
    logic [vom_pkg::COOL_W-1:0]  cool_q, cool_d;   // Shared cooling timer
    logic [NP-1:0]               dly1_q, dly2_q;   // Drive delayed to match sensing
    logic [NP-1:0] fault_now;
    always_comb begin
        // Drive must have stood through both sync stages, else a turn-on
        // would read as a fault before its sensed level arrives
        fault_now = eff_cmd & out_drive & dly2_q & ~fs2_q.sense_hi;
        lat_d     = lat_q;
        prev_d    = eff_cmd;
        // Timer restarts at each fault, so every retry waits a full cooling time
        if (|fault_now)
            cool_d = vom_pkg::COOL_W'(vom_pkg::COOL_CYC - 1);
        else if (cool_q != '0)
            cool_d = cool_q - 1'b1;
        else
            cool_d = cool_q;
        for (int p = 0; p < NP; p++) begin
            if (!eff_cmd[p])
                lat_d[p] = lat_q[p] & ~cfg.auto_restart;       // Off keeps latch unless auto restart
            else if (fault_now[p])
                lat_d[p] = 1'b1;
            else if (lat_q[p] && !prev_q[p])
                lat_d[p] = 1'b0;                               // Off then on re-enables
            else if (lat_q[p] && cfg.auto_restart && cool_q == '0)
                lat_d[p] = 1'b0;                               // Retry after cooling
        end
    end
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            lat_q  <= '0;
            prev_q <= '0;
            cool_q <= '0;
            dly1_q <= '0;
            dly2_q <= '0;
        end else begin
            lat_q  <= lat_d;
            prev_q <= prev_d;
            cool_q <= cool_d;
            dly1_q <= out_drive;
            dly2_q <= dly1_q;
        end
    end

    // Read-back, status and indicators, all registered
    logic [NP-1:0] rb_d, drv_d, led_d;
    logic [7:0]    stat_d;
    logic          fled_d;
    logic [NP-1:0] mis;     // Per-point miscompare
    always_comb begin
        drv_d = eff_cmd & ~lat_d;
        led_d = drv_d;                                         // Indicator follows output
        if (cfg.rb_mode == vom_pkg::VOM_RB_RAW)
            mis = ~eff_cmd & fs2_q.sense_hi;
        else
            mis = lat_d | (eff_cmd ^ fs2_q.sense_hi) & ~(eff_cmd & ~out_drive);
        unique case (cfg.rb_mode)
            vom_pkg::VOM_RB_HEALTH: rb_d = ~(lat_d | mis);
            vom_pkg::VOM_RB_FAULT:  rb_d = lat_d | mis;
            vom_pkg::VOM_RB_RAW:    rb_d = fs2_q.sense_hi;
            vom_pkg::VOM_RB_ACTUAL: rb_d = fs2_q.sense_hi & ~lat_d;
        endcase
        for (int g = 0; g < NG; g++) begin
            stat_d[vom_pkg::STAT_VF_LSB + g] =
                ~(fs2_q.supply_ok[g] & fs2_q.fuse_ok[g]);
            stat_d[vom_pkg::STAT_MC_LSB + g] = |mis[g*GP +: GP];
        end
        fled_d = |stat_d;
    end
    logic [NP-1:0] rb_q;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rb_q        <= '0;
            out_drive   <= '0;
            out_led     <= '0;
            status_byte <= '0;
            fault_led   <= 1'b0;
            active_led  <= 1'b0;
        end else begin
            rb_q        <= rb_d;
            out_drive   <= drv_d;
            out_led     <= led_d;
            status_byte <= stat_d;
            fault_led   <= fled_d;
            active_led  <= ~lost_d;
        end
    end

    // Sense words, point 1 and point 17 in the MSBs
    always_comb begin
        sense_bits = rb_q;
        for (int i = 0; i < 16; i++) begin
            sense_word_lo[15-i] = rb_q[i];
            sense_word_hi[15-i] = rb_q[16 + i];
        end
    end

    // Checks; each label names the rule it guards
    // No loss within eight cycles of an update
    property p_loss_after_timeout;
        @(posedge mclk) disable iff (sys_rst)
        (cmd_valid ##1 !cmd_valid [*8]) |-> !lost_q;
    endproperty
    a_loss_after_timeout: assert property (p_loss_after_timeout)
        else $error("early loss");

    // Loss is declared once the timer reaches its end without an update
    property p_loss_at_timeout;
        @(posedge mclk) disable iff (sys_rst)
        (!cmd_valid && tmo_q == vom_pkg::TIMEOUT_W'(vom_pkg::TIMEOUT_CYC - 1)) |=> lost_q;
    endproperty
    a_loss_at_timeout: assert property (p_loss_at_timeout)
        else $error("loss not declared");

    // Active indicator is the inverse of the loss flag
    property p_active_led;
        @(posedge mclk) disable iff (sys_rst)
        active_led != lost_q;
    endproperty
    a_active_led: assert property (p_active_led)
        else $error("active indicator wrong");

    // Disabled shutdown forces every point off
    property p_disable_all_off;
        @(posedge mclk) disable iff (sys_rst)
        (lost_q && cfg.shut_disable) |=> out_drive == '0;
    endproperty
    a_disable_all_off: assert property (p_disable_all_off)
        else $error("outputs on in disable");

    // Group zero with fail state off goes dark on loss
    property p_fail_off;
        @(posedge mclk) disable iff (sys_rst)
        (lost_q && !cfg.shut_disable && !cfg.fail_hold[0]) |=> out_drive[7:0] == '0;
    endproperty
    a_fail_off: assert property (p_fail_off)
        else $error("group 0 not off");

    // Missing supply shows in the status byte one cycle on
    property p_vfault;
        @(posedge mclk) disable iff (sys_rst)
        !fs2_q.supply_ok[1] |=> status_byte[vom_pkg::STAT_VF_LSB + 1];
    endproperty
    a_vfault: assert property (p_vfault)
        else $error("voltage fault missing");

    // A latched point is never driven
    property p_latched_off;
        @(posedge mclk) disable iff (sys_rst)
        lat_q[0] |-> !out_drive[0] || !$past(lat_q[0]);
    endproperty
    a_latched_off: assert property (p_latched_off)
        else $error("latched point driven");

    // Latched mode: an off command keeps the latch
    property p_latch_holds;
        @(posedge mclk) disable iff (sys_rst)
        (!cfg.auto_restart && lat_q[0] && !eff_cmd[0]) |=> lat_q[0];
    endproperty
    a_latch_holds: assert property (p_latch_holds)
        else $error("latch lost on off");

    // Auto restart: an off command clears the latch
    property p_auto_off_clears;
        @(posedge mclk) disable iff (sys_rst)
        (cfg.auto_restart && !eff_cmd[0]) |=> !lat_q[0];
    endproperty
    a_auto_off_clears: assert property (p_auto_off_clears)
        else $error("latch kept on off");

    // Health bit is low exactly where a fault or miscompare stood
    property p_health_fault_opposite;
        @(posedge mclk) disable iff (sys_rst)
        cfg.rb_mode == vom_pkg::VOM_RB_HEALTH |=>
            rb_q[0] != ($past(lat_d[0]) || $past(mis[0]));
    endproperty
    a_health_fault_opposite: assert property (p_health_fault_opposite)
        else $error("health bit wrong");

    // Raw mode returns the synchronised terminal level
    property p_raw_follows;
        @(posedge mclk) disable iff (sys_rst)
        cfg.rb_mode == vom_pkg::VOM_RB_RAW |=> rb_q == $past(fs2_q.sense_hi);
    endproperty
    a_raw_follows: assert property (p_raw_follows)
        else $error("raw bit wrong");

    // Any status bit lights the fault indicator
    property p_fault_led;
        @(posedge mclk) disable iff (sys_rst)
        |status_byte |-> fault_led;
    endproperty
    a_fault_led: assert property (p_fault_led)
        else $error("fault indicator dark");

    // Point indicators mirror the drivers
    property p_led_follows;
        @(posedge mclk) disable iff (sys_rst)
        out_led == out_drive;
    endproperty
    a_led_follows: assert property (p_led_follows)
        else $error("point indicator wrong");

    // Point 1 and point 17 sit at the word tops
    property p_word_order;
        @(posedge mclk) disable iff (sys_rst)
        sense_word_lo[15] == rb_q[0] && sense_word_hi[15] == rb_q[16];
    endproperty
    a_word_order: assert property (p_word_order)
        else $error("sense word order");

    // Main scenarios reached
    c_loss: cover property (@(posedge mclk) disable iff (sys_rst) $rose(lost_q));
    c_latch: cover property (@(posedge mclk) disable iff (sys_rst) $rose(lat_q[0]));
    c_clear: cover property (@(posedge mclk) disable iff (sys_rst) $fell(lat_q[0]));
    c_raw_mis: cover property (@(posedge mclk) disable iff (sys_rst)
        cfg.rb_mode == vom_pkg::VOM_RB_RAW && status_byte[vom_pkg::STAT_MC_LSB + 1]);
    c_retry: cover property (@(posedge mclk) disable iff (sys_rst)
        cfg.auto_restart && $fell(lat_q[19]));
endmodule : vom_top
